// ===== inc/ldrb_pkg.sv
// Constants and types for the LED driver I2C register bank
`default_nettype none
package ldrb_pkg;
    localparam logic [6:0] ADDR_FUSE_00 = 7'h14;
    localparam logic [6:0] ADDR_FUSE_01 = 7'h10;
    localparam logic [6:0] ADDR_FUSE_10 = 7'h1C;
    localparam logic [6:0] ADDR_FUSE_11 = 7'h18;
    localparam int NUM_REGS = 5;
    localparam logic [2:0] IDX_STATUS = 3'h0;
    localparam logic [2:0] IDX_LED = 3'h1;
    localparam logic [2:0] IDX_MAIN = 3'h2;
    localparam logic [2:0] IDX_SUB = 3'h3;
    localparam logic [2:0] IDX_KEYPAD = 3'h4;
    localparam logic [2:0] IDX_LAST = 3'h4;
    localparam int BIT_PWR_HI = 7;
    localparam int BIT_PWR_LO = 6;
    localparam int BIT_FORCE = 0;
    localparam int BIT_FORCED_MULT = 0;
    localparam int CODE_MSB = 7;
    localparam int CODE_LSB = 2;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] STATUS_WR_MASK = 8'hC1;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] PWR_OFF_CLEAR = 2'h0;
    localparam logic [1:0] PWR_OFF_KEEP = 2'h1;
    localparam logic [1:0] PWR_STANDBY = 2'h2;
    localparam logic [1:0] PWR_ACTIVE = 2'h3;
    localparam logic [5:0] CODE_ZERO = 6'h00;
    localparam logic [5:0] CODE_TRICKLE = 6'h01;
    localparam logic [15:0] TRICKLE_UA = 16'h001F;
    localparam logic [15:0] STEP_NARROW_UA = 16'h01F4;
    localparam logic [15:0] STEP_WIDE_UA = 16'h03E8;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ACK, ST_WDATA, ST_RDATA, ST_MACK, ST_WAIT
    } ldrb_state_t;
endpackage
`default_nettype wire

// ===== rtl/ldrb_reg_bank.sv
// I2C slave register bank of the seven-channel LED backlight driver
// Functional notes
// RULE_01 - Master starts every transfer and clocks it; device only answers.
// RULE_02 - Slave address chosen by two fuses: 14, 10, 1C, 18 hex.
// RULE_03 - Write order: address, status, LED enable, main, sub, keypad.
// RULE_04 - A full write cycle is six bytes including the address.
// RULE_05 - Each data byte takes effect right after its acknowledge.
// RULE_06 - Power bits 00: shutdown, LEDs off, all registers cleared.
// RULE_07 - Power bits 01: shutdown, LEDs off, registers kept.
// RULE_08 - Power bits 10: standby, references on, bypass on, LEDs off.
// RULE_09 - Power bits 11: active, enabled LEDs at programmed current.
// RULE_10 - Status bits 5 to 1 are read-only.
// RULE_11 - Status bit 5 high while any fault exists.
// RULE_12 - Bits 4, 3, 2 report overvoltage, overtemperature, undervoltage.
// RULE_13 - Status bit 1 shows pump multiplier, 1 for 1.5x.
// RULE_14 - Status bit 0 low selects automatic pump mode, high forces it.
// RULE_15 - Forced mode: enable bit 0 picks 1x or 1.5x; else ignored.
// RULE_16 - Enable bits 1-4 main, 5-6 sub, 7 keypad LED.
// RULE_17 - Any fault turns LEDs off, registers unchanged.
// RULE_18 - Operation resumes by itself when the fault clears.
// RULE_19 - Current code in bits 7 to 2; bits 1, 0 ignored.
// RULE_20 - Code 0 zero, 1 trickle, else code times step.
// RULE_21 - One code sets the current of its whole group.
// RULE_22 - A shorted LED has its output switched off.
// RULE_23 - Reads return status first, then registers in write order.
`timescale 1ns/1ps
`default_nettype none
module ldrb_reg_bank (
    input wire logic ref_clk, // 125 MHz clock
    input wire logic rst_n, // Synchronous reset
    input wire logic sclIn, // Bus clock level
    input wire logic sdaIn, // Bus data level
    output logic sdaOut, // Data drive value, always low
    output logic sdaOe, // Pull data low
    input wire logic addressFuseHigh, // Address fuse 1
    input wire logic addressFuseLow, // Address fuse 0
    input wire logic overvoltageFlag, // Overvoltage detector
    input wire logic overtemperatureFlag, // Overtemperature detector
    input wire logic undervoltageLockoutFlag, // Undervoltage detector
    input wire logic autoPumpRequest, // Dropout logic asks for 1.5x
    input wire logic [6:0] shortedLed, // Short detector per output
    output logic [6:0] currentSinkOutputs, // Sink on per output
    output logic [15:0] mainCurrentUa, // Main sink current, uA
    output logic [15:0] subCurrentUa, // Sub sink current, uA
    output logic [15:0] keypadCurrentUa, // Keypad sink current, uA
    output logic pumpMultiplierState, // 1 selects 1.5x
    output logic shutdownActive, // Part shut down
    output logic analogRefEnable, // References powered
    output logic bypassSwitch // Input shorted to output
);
    function automatic logic [15:0] codeToUa(input logic [7:0] regVal,
                                             input logic [15:0] step);
        logic [5:0] code;
        code = regVal[ldrb_pkg::CODE_MSB:ldrb_pkg::CODE_LSB]; // [RULE_19]
        if (code == ldrb_pkg::CODE_ZERO)
            codeToUa = 16'h0000; // [RULE_20]
        else if (code == ldrb_pkg::CODE_TRICKLE)
            codeToUa = ldrb_pkg::TRICKLE_UA; // [RULE_20]
        else
            codeToUa = 16'(code) * step; // [RULE_20]
    endfunction

    logic [7:0] regFile_reg [ldrb_pkg::NUM_REGS];
    ldrb_pkg::ldrb_state_t state_reg, state_next;
    logic [3:0] bitCnt_reg, bitCnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] tx_reg, tx_next;
    logic [2:0] byteIdx_reg, byteIdx_next;
    logic addrPhase_reg, addrPhase_next;
    logic readMode_reg, readMode_next;
    logic sdaOe_reg, sdaOe_next;
    logic sclPrev_reg, sdaPrev_reg;
    logic applyByte;
    logic [6:0] sinks_reg;
    logic [15:0] mainUa_reg, subUa_reg, keyUa_reg;
    logic pump_reg;

    wire sclRise = sclIn & ~sclPrev_reg;
    wire sclFall = ~sclIn & sclPrev_reg;
    wire startSeen = sclIn & sclPrev_reg & sdaPrev_reg & ~sdaIn;
    wire stopSeen = sclIn & sclPrev_reg & ~sdaPrev_reg & sdaIn;
    wire [6:0] ownAddr = addressFuseHigh ?
        (addressFuseLow ? ldrb_pkg::ADDR_FUSE_11 : ldrb_pkg::ADDR_FUSE_10) :
        (addressFuseLow ? ldrb_pkg::ADDR_FUSE_01 : ldrb_pkg::ADDR_FUSE_00);
    wire [7:0] statusReg = regFile_reg[ldrb_pkg::IDX_STATUS];
    wire [7:0] ledEnableReg = regFile_reg[ldrb_pkg::IDX_LED];
    wire [1:0] powerState = {statusReg[ldrb_pkg::BIT_PWR_HI],
                             statusReg[ldrb_pkg::BIT_PWR_LO]};
    wire pumpForceSelect = statusReg[ldrb_pkg::BIT_FORCE];
    wire anyFaultFlag = overvoltageFlag | overtemperatureFlag
                        | undervoltageLockoutFlag; // [RULE_11] [RULE_17]
    wire pumpNext = pumpForceSelect // [RULE_14]
        ? ledEnableReg[ldrb_pkg::BIT_FORCED_MULT] : autoPumpRequest; // [RULE_15]
    wire [7:0] statusLive = {powerState, anyFaultFlag, overvoltageFlag,
        overtemperatureFlag, undervoltageLockoutFlag, pump_reg,
        pumpForceSelect}; // [RULE_10] [RULE_12] [RULE_13]
    wire [7:0] readByte = (byteIdx_reg == ldrb_pkg::IDX_STATUS) ?
        statusLive : regFile_reg[byteIdx_reg]; // [RULE_23]
    wire driveOn = (powerState == ldrb_pkg::PWR_ACTIVE)
                   & ~anyFaultFlag; // [RULE_09] [RULE_17] [RULE_18]
    wire [6:0] sinksNext = {7{driveOn}} & ledEnableReg[7:1]
                           & ~shortedLed; // [RULE_16] [RULE_22]
    wire clearAll = applyByte & (byteIdx_reg == ldrb_pkg::IDX_STATUS)
        & (shift_reg[7:6] == ldrb_pkg::PWR_OFF_CLEAR); // [RULE_06]
    wire [7:0] storeVal = (byteIdx_reg == ldrb_pkg::IDX_STATUS) ?
        (shift_reg & ldrb_pkg::STATUS_WR_MASK) : shift_reg; // [RULE_10]

    always_comb begin
        state_next = state_reg;
        bitCnt_next = bitCnt_reg;
        shift_next = shift_reg;
        tx_next = tx_reg;
        byteIdx_next = byteIdx_reg;
        addrPhase_next = addrPhase_reg;
        readMode_next = readMode_reg;
        sdaOe_next = sdaOe_reg;
        applyByte = 1'b0;
        if (stopSeen) begin
            state_next = ldrb_pkg::ST_IDLE;
            sdaOe_next = 1'b0;
        end else if (startSeen) begin
            state_next = ldrb_pkg::ST_ADDR;
            bitCnt_next = 4'h0;
            byteIdx_next = ldrb_pkg::IDX_STATUS;
            addrPhase_next = 1'b1;
            sdaOe_next = 1'b0;
        end else begin
            case (state_reg)
                ldrb_pkg::ST_ADDR, ldrb_pkg::ST_WDATA: begin
                    if (sclRise && bitCnt_reg != ldrb_pkg::BITS_PER_BYTE) begin
                        shift_next = {shift_reg[6:0], sdaIn};
                        bitCnt_next = bitCnt_reg + 4'h1;
                    end else if (sclFall
                                 && bitCnt_reg == ldrb_pkg::BITS_PER_BYTE) begin
                        bitCnt_next = 4'h0;
                        if (state_reg == ldrb_pkg::ST_ADDR) begin
                            if (shift_reg[7:1] == ownAddr) begin // [RULE_02]
                                state_next = ldrb_pkg::ST_ACK;
                                sdaOe_next = 1'b1;
                                readMode_next = shift_reg[0];
                            end else begin
                                state_next = ldrb_pkg::ST_WAIT;
                            end
                        end else if (byteIdx_reg <= ldrb_pkg::IDX_LAST) begin
                            state_next = ldrb_pkg::ST_ACK; // [RULE_04]
                            sdaOe_next = 1'b1;
                        end else begin
                            state_next = ldrb_pkg::ST_WAIT;
                        end
                    end
                end
                ldrb_pkg::ST_ACK: begin
                    if (sclFall) begin
                        sdaOe_next = 1'b0;
                        addrPhase_next = 1'b0;
                        state_next = ldrb_pkg::ST_WDATA;
                        if (addrPhase_reg && readMode_reg) begin
                            state_next = ldrb_pkg::ST_RDATA; // [RULE_23]
                            tx_next = {readByte[6:0], 1'b0};
                            sdaOe_next = ~readByte[7];
                            bitCnt_next = 4'h1;
                        end else if (!addrPhase_reg) begin
                            applyByte = 1'b1; // [RULE_05]
                            byteIdx_next = byteIdx_reg + 3'h1; // [RULE_03]
                        end
                    end
                end
                ldrb_pkg::ST_RDATA: begin
                    if (sclFall) begin
                        if (bitCnt_reg == ldrb_pkg::BITS_PER_BYTE) begin
                            sdaOe_next = 1'b0;
                            state_next = ldrb_pkg::ST_MACK;
                        end else begin
                            sdaOe_next = ~tx_reg[7];
                            tx_next = {tx_reg[6:0], 1'b0};
                            bitCnt_next = bitCnt_reg + 4'h1;
                        end
                    end
                end
                ldrb_pkg::ST_MACK: begin
                    if (sclRise) begin
                        if (sdaIn) begin
                            state_next = ldrb_pkg::ST_WAIT;
                        end else begin
                            state_next = ldrb_pkg::ST_ACK;
                            addrPhase_next = 1'b1;
                            byteIdx_next = (byteIdx_reg == ldrb_pkg::IDX_LAST)
                                ? ldrb_pkg::IDX_STATUS
                                : byteIdx_reg + 3'h1; // [RULE_23]
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg <= ldrb_pkg::ST_IDLE;
            bitCnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            byteIdx_reg <= 3'h0;
            addrPhase_reg <= 1'b0;
            readMode_reg <= 1'b0;
            sdaOe_reg <= 1'b0;
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            bitCnt_reg <= bitCnt_next;
            shift_reg <= shift_next;
            tx_reg <= tx_next;
            byteIdx_reg <= byteIdx_next;
            addrPhase_reg <= addrPhase_next;
            readMode_reg <= readMode_next;
            sdaOe_reg <= sdaOe_next; // [RULE_01]
            sclPrev_reg <= sclIn;
            sdaPrev_reg <= sdaIn;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || clearAll) begin
            for (int i = 0; i < ldrb_pkg::NUM_REGS; i++) begin
                regFile_reg[i] <= ldrb_pkg::REG_RESET; // [RULE_06]
            end
        end else if (applyByte) begin
            regFile_reg[byteIdx_reg] <= storeVal; // [RULE_05] [RULE_07]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sinks_reg <= 7'h00;
            mainUa_reg <= 16'h0000;
            subUa_reg <= 16'h0000;
            keyUa_reg <= 16'h0000;
            pump_reg <= 1'b0;
        end else begin
            sinks_reg <= sinksNext; // [RULE_07] [RULE_08] [RULE_17]
            mainUa_reg <= codeToUa(regFile_reg[ldrb_pkg::IDX_MAIN],
                                   ldrb_pkg::STEP_NARROW_UA); // [RULE_21]
            subUa_reg <= codeToUa(regFile_reg[ldrb_pkg::IDX_SUB],
                                  ldrb_pkg::STEP_NARROW_UA); // [RULE_21]
            keyUa_reg <= codeToUa(regFile_reg[ldrb_pkg::IDX_KEYPAD],
                                  ldrb_pkg::STEP_WIDE_UA); // [RULE_21]
            pump_reg <= pumpNext; // [RULE_13]
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOe = sdaOe_reg;
    assign currentSinkOutputs = sinks_reg;
    assign mainCurrentUa = mainUa_reg;
    assign subCurrentUa = subUa_reg;
    assign keypadCurrentUa = keyUa_reg;
    assign pumpMultiplierState = pump_reg;
    assign shutdownActive = ~powerState[1]; // [RULE_07]
    assign analogRefEnable = powerState[1]; // [RULE_08]
    assign bypassSwitch = (powerState == ldrb_pkg::PWR_STANDBY); // [RULE_08]

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    slave_only_a: assert property ( // [RULE_01]
        sdaOe_reg |-> (state_reg == ldrb_pkg::ST_ACK
                       || state_reg == ldrb_pkg::ST_RDATA))
        else $error("data driven outside acknowledge or read");
    addr_match_a: assert property ( // [RULE_02]
        (state_reg == ldrb_pkg::ST_ACK && addrPhase_reg && sdaOe_reg)
        |-> shift_reg[7:1] == ownAddr)
        else $error("acknowledged a foreign address");
    apply_after_ack_a: assert property ( // [RULE_05]
        (applyByte && byteIdx_reg == ldrb_pkg::IDX_MAIN)
        |=> regFile_reg[ldrb_pkg::IDX_MAIN] == $past(shift_reg))
        else $error("main code not applied after acknowledge");
    clear_all_a: assert property ( // [RULE_06]
        clearAll |=> (regFile_reg[ldrb_pkg::IDX_LED] == 8'h00
                      && regFile_reg[ldrb_pkg::IDX_KEYPAD] == 8'h00))
        else $error("registers not cleared on shutdown");
    idle_dark_a: assert property ( // [RULE_07]
        (powerState != ldrb_pkg::PWR_ACTIVE) [*2] |-> sinks_reg == 7'h00)
        else $error("LED driven while not active");
    standby_a: assert property ( // [RULE_08]
        (powerState == ldrb_pkg::PWR_STANDBY)
        |-> (bypassSwitch && analogRefEnable && !shutdownActive))
        else $error("standby outputs wrong");
    active_drive_a: assert property ( // [RULE_09]
        (driveOn && ledEnableReg[7:1] != 7'h00 && shortedLed == 7'h00)
        |=> sinks_reg == $past(ledEnableReg[7:1]))
        else $error("enabled LEDs not driven when active");
    fault_off_a: assert property ( // [RULE_17]
        anyFaultFlag |=> sinks_reg == 7'h00)
        else $error("LED driven during a fault");
    fault_resume_a: assert property ( // [RULE_18]
        ($fell(anyFaultFlag) && powerState == ldrb_pkg::PWR_ACTIVE
         && $stable(ledEnableReg) && shortedLed == 7'h00)
        |=> sinks_reg == $past(ledEnableReg[7:1]))
        else $error("no recovery after fault cleared");
    pump_force_a: assert property ( // [RULE_15]
        pumpForceSelect |=> pump_reg == $past(ledEnableReg[0]))
        else $error("forced pump mode not followed");
    pump_auto_a: assert property ( // [RULE_14]
        !pumpForceSelect |=> pump_reg == $past(autoPumpRequest))
        else $error("automatic pump mode not followed");
    trickle_code_a: assert property ( // [RULE_20]
        (regFile_reg[ldrb_pkg::IDX_KEYPAD][7:2] == ldrb_pkg::CODE_TRICKLE)
        |=> keyUa_reg == ldrb_pkg::TRICKLE_UA)
        else $error("trickle code decoded wrong");
    short_off_a: assert property ( // [RULE_22]
        shortedLed[0] |=> !sinks_reg[0])
        else $error("shorted output still driven");

    write_six_c: cover property (applyByte
        && byteIdx_reg == ldrb_pkg::IDX_KEYPAD);
    read_status_c: cover property (state_reg == ldrb_pkg::ST_RDATA
        && byteIdx_reg == ldrb_pkg::IDX_STATUS);
    fault_recover_c: cover property ($fell(anyFaultFlag) && driveOn);
endmodule
`default_nettype wire

// ===== dv/ldrb_host_model.sv
// Behavioural I2C bus master standing in for the host processor
`timescale 1ns/1ps
`default_nettype none
module ldrb_host_model (
    input wire logic clk, // Bench clock
    input wire logic sdaLine, // Resolved data wire
    output logic scl, // Bus clock from the master
    output logic sdaLow // Master pulls data low
);
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic hp();
        repeat (4) @(negedge clk);
    endtask
    // Master alone starts frames and drives the clock
    task automatic start();
        sdaLow = 1'b0;
        hp();
        scl = 1'b1;
        hp();
        sdaLow = 1'b1;
        hp();
        scl = 1'b0;
        hp();
    endtask
    task automatic stop();
        sdaLow = 1'b1;
        hp();
        scl = 1'b1;
        hp();
        sdaLow = 1'b0;
        hp();
    endtask
    // Bytes go MSB first, one ack slot each
    task automatic sendByte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sdaLow = ~b[i];
            hp();
            scl = 1'b1;
            hp();
            scl = 1'b0;
            hp();
        end
        sdaLow = 1'b0;
        hp();
        scl = 1'b1;
        hp();
        ack = ~sdaLine;
        scl = 1'b0;
        hp();
    endtask
    task automatic readByte(input logic mack, output logic [7:0] b);
        sdaLow = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            hp();
            scl = 1'b1;
            hp();
            b[i] = sdaLine;
            scl = 1'b0;
        end
        hp();
        sdaLow = mack;
        hp();
        scl = 1'b1;
        hp();
        scl = 1'b0;
        hp();
    endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the LED driver register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rstN = 1'b0;
    logic scl, hostLow, sdaOe, sdaOut, ov = 0, ot = 0, uv = 0, autoReq = 0;
    logic [1:0] fuse = 2'h0;
    logic [6:0] shorted = 7'h00, sinks;
    logic [15:0] mainUa, subUa, keyUa;
    logic pump, shutdown, refEn, bypass, ack;
    logic [7:0] rb;
    wire logic sdaLine;
    int m[5], dv[6], n_errors = 0, compares = 0;
    assign sdaLine = (sdaOe ? sdaOut : 1'b1) & ~hostLow;
    always #4 clk = ~clk;
    ldrb_host_model host (.clk(clk), .sdaLine(sdaLine), .scl(scl),
        .sdaLow(hostLow));
    ldrb_reg_bank uut (.ref_clk(clk), .rst_n(rstN), .sclIn(scl),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .addressFuseHigh(fuse[1]), .addressFuseLow(fuse[0]),
        .overvoltageFlag(ov), .overtemperatureFlag(ot),
        .undervoltageLockoutFlag(uv), .autoPumpRequest(autoReq),
        .shortedLed(shorted), .currentSinkOutputs(sinks),
        .mainCurrentUa(mainUa), .subCurrentUa(subUa),
        .keypadCurrentUa(keyUa), .pumpMultiplierState(pump),
        .shutdownActive(shutdown), .analogRefEnable(refEn),
        .bypassSwitch(bypass));
    function automatic int cur(input int code, input int step);
        return (code == 0) ? 0 : (code == 1) ? 31 : code * step;
    endfunction
    function automatic logic [6:0] addrOf(input logic [1:0] f);
        return (f == 2'h0) ? ldrb_pkg::ADDR_FUSE_00 :
            (f == 2'h1) ? ldrb_pkg::ADDR_FUSE_01 :
            (f == 2'h2) ? ldrb_pkg::ADDR_FUSE_10 : ldrb_pkg::ADDR_FUSE_11;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s seen %0h expected %0h", $time, what,
                seen, exp);
        end
    endtask
    task automatic checkOuts();
        int pwr, any_fault_flag, pm, es;
        pwr = m[0] >> 6;
        any_fault_flag = ov | ot | uv;
        pm = (m[0] & 1) ? (m[1] & 1) : autoReq;
        es = (pwr == 3 && any_fault_flag == 0) ? ((m[1] >> 1) & ~shorted & 'h7F) : 0;
        chk(sinks, es, "sinks");
        chk(mainUa, cur(m[2] >> 2, 500), "main");
        chk(subUa, cur(m[3] >> 2, 500), "sub");
        chk(keyUa, cur(m[4] >> 2, 1000), "keypad");
        chk(pump, pm, "pump");
        chk(shutdown, pwr < 2, "shutdown");
        chk(refEn, pwr >= 2, "reference");
        chk(bypass, pwr == 2, "bypass");
    endtask
    // Outputs checked before the stop condition
    task automatic wr(input logic [6:0] a, input int n);
        host.start();
        host.sendByte({a, 1'b0}, ack);
        chk(ack, a == addrOf(fuse), "address ack");
        for (int k = 0; k < n && a == addrOf(fuse); k++) begin
            host.sendByte(dv[k][7:0], ack);
            chk(ack, k < 5, "data ack");
            if (k == 0 && (dv[0] & 'hC0) == 0) begin
                m = '{0, 0, 0, 0, 0};
            end else if (k == 0) begin
                m[0] = dv[0] & 'hC1;
            end else if (k < 5) begin
                m[k] = dv[k] & 'hFF;
            end
            repeat (4) @(negedge clk);
            checkOuts();
        end
        host.stop();
    endtask
    task automatic rd(input int n);
        int st;
        host.start();
        host.sendByte({addrOf(fuse), 1'b1}, ack);
        for (int k = 0; k < n; k++) begin
            host.readByte(k < n - 1, rb);
            st = (m[0] & 'hC1) | ((ov | ot | uv) << 5) | (ov << 4) |
                (ot << 3) | (uv << 2) |
                (((m[0] & 1) ? (m[1] & 1) : int'(autoReq)) << 1);
            chk(rb, (k % 5 == 0) ? st : m[k % 5], "readback");
        end
        host.stop();
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_errors++;
        final_report();
    end
    initial begin
        m = '{0, 0, 0, 0, 0};
        repeat (8) @(negedge clk);
        rstN = 1'b1;
        void'($urandom(24));
        checkOuts();
        for (int f = 0; f < 4; f++) begin
            fuse = f[1:0];
            foreach (dv[i]) dv[i] = $urandom & 'hFF;
            dv[0] = 'hC0 | (dv[0] & 1);
            wr(addrOf(fuse), 5);
            wr(addrOf(fuse) ^ 7'h04, 5);
            rd(6);
        end
        $display("test address and write done");
        for (int p = 3; p >= 0; p--) begin
            dv[0] = (p << 6) | 'h3E;
            wr(addrOf(fuse), 1);
            rd(5);
        end
        $display("test power states done");
        dv = '{'hC0, 'hFE, 'h80, 'h40, 'h20, 0};
        wr(addrOf(fuse), 5);
        for (int i = 0; i < 3; i++) begin
            {ov, ot, uv} = 3'h4 >> i;
            repeat (4) @(negedge clk);
            checkOuts();
            rd(1);
            {ov, ot, uv} = 3'h0;
            repeat (4) @(negedge clk);
            checkOuts();
        end
        $display("test faults done");
        for (int i = 0; i < 8; i++) begin
            autoReq = 1'($urandom);
            shorted = 7'($urandom);
            foreach (dv[j]) dv[j] = $urandom & 'hFF;
            dv[0] = 'hC0 | (dv[0] & 1);
            dv[2] = (i == 0) ? 0 : (i == 1) ? 'h07 : (i == 2) ? 'h0B : 'hFF;
            if (i == 1) dv[4] = 'h05;
            wr(addrOf(fuse), 6);
            rd(2);
        end
        $display("test pump codes shorts done");
        final_report();
    end
endmodule
`default_nettype wire
